/* logic/srsl_status.sv */
// Status byte and service request summary of the environment monitor.
// Assumes condition inputs are on mclk already (they come from firmware-side logic).
//
// Functional notes
// - Enable mask written as 8-bit value
// - Mask bit 6 ignored in summary
// - Summary set from masked status bits
// - Summary rise issues request-true interrupt
// - Summary fall issues request-false interrupt
// - Mask query returns last written value
// - Status bits 0,1,2,7 read zero
// - Bit 3 from masked questionable condition
// - Bit 4 while reply is pending
// - Bit 5 from masked standard events
// - Query and serial poll same value
// - Bit true means condition true
// - Event flag ORs masked event bits
// - Instrument reset leaves status unchanged
//
// =====================================================
// Usage notes
// The enable mask is written by a one-cycle strobe carrying the whole byte.
// All eight mask bits are stored and read back, bit 6 included, so a query
// returns exactly what was written; only the summary leaves bit 6 out.
// The status byte is registered: every bit follows its condition inputs
// with one cycle of lag, and the summary bit is built from the same inputs
// and the registered mask, so it lags a mask write by one more cycle.
// Query and serial poll read one shared register, so they can never differ.
// Request pulses are registered together with the status byte, so a pulse
// stands in the very cycle in which the summary bit changes on the output.
// A summary that toggles every cycle yields one pulse per edge; the bus side
// must take a pulse every cycle if the conditions can toggle that fast.
// The instrument reset command is wired in only so that its harmlessness
// can be checked; no register here listens to it.
// Condition inputs must already be on mclk; they come from logic in this
// clock domain, so no synchroniser stages are placed in front of them.
//
`timescale 1ns/1ps
`include "srsl_defs.svh"
module srsl_status (
    input wire logic mclk, // 50 MHz system clock
    input wire logic sys_rst, // Power-on reset, synchronous, high
    input wire srsl_pkg::srsl_wr_t mask_cmd, // Enable mask write command
    input wire logic inst_rst, // Instrument reset command pulse
    input wire logic [7:0] ques_cond, // Questionable condition register
    input wire logic [7:0] ques_enable, // Questionable enable register
    input wire logic reply_pending, // Reply waiting in output buffer
    input wire logic [7:0] standard_event_register, // Standard event register
    input wire logic [7:0] standard_event_enable_mask, // Standard event enable
    output logic [7:0] service_request_enable_mask, // Mask readback
    output logic [7:0] status_summary_byte, // Status byte for query
    output logic [7:0] serial_poll_byte, // Status byte for serial poll
    output srsl_pkg::srsl_irq_t irq // Request interrupt pulses
);
    import srsl_pkg::*;

    // =====================================================
    // Enable mask register
    logic [7:0] mask_r; // Stored mask
    logic [7:0] mask_nxt; // Next mask

    // Write takes the full byte; instrument reset has no effect on it
    always_comb begin
        mask_nxt = mask_r;
        if (mask_cmd.wr) begin
            mask_nxt = mask_cmd.data;
        end
    end

    // Power-on clear so no request fires until software enables one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_r <= `SRSL_MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // =====================================================
    // Status byte assembly
    logic event_summary_flag; // Masked standard event summary
    logic ques_summary; // Masked questionable summary
    logic [7:0] status_raw; // Byte without the summary bit
    logic master_summary_bit; // Combinational summary

    always_comb begin
        event_summary_flag = |(standard_event_register & standard_event_enable_mask);
        ques_summary = |(ques_cond & ques_enable);
        status_raw = 8'h00;
        status_raw[`SRSL_BIT_QUES] = ques_summary;
        status_raw[`SRSL_BIT_REPLY] = reply_pending;
        status_raw[`SRSL_BIT_EVENT] = event_summary_flag;
        // Bit 6 of the mask is dropped so the summary cannot enable itself
        master_summary_bit = |(status_raw & mask_r & `SRSL_SUMMARY_MASK);
    end

    // =====================================================
    // Registered status byte and edge state
    logic [7:0] status_r; // Registered status byte
    logic [7:0] status_nxt; // Next status byte
    srsl_state_t state_r; // Summary level as state
    srsl_state_t state_nxt; // Next state
    srsl_irq_t irq_r; // Registered pulses
    srsl_irq_t irq_nxt; // Next pulses

    // Edges of the summary bit raise one-cycle request pulses
    always_comb begin
        status_nxt = status_raw;
        status_nxt[`SRSL_BIT_SUMMARY] = master_summary_bit;
        irq_nxt = '0;
        state_nxt = state_r;
        case (state_r)
            SRSL_IDLE: begin
                if (master_summary_bit) begin
                    state_nxt = SRSL_ACTIVE;
                    irq_nxt.req_true = 1'b1;
                end
            end
            SRSL_ACTIVE: begin
                if (!master_summary_bit) begin
                    state_nxt = SRSL_IDLE;
                    irq_nxt.req_false = 1'b1;
                end
            end
            default: begin
                state_nxt = SRSL_IDLE;
            end
        endcase
    end

    // Only power-on reset clears state; instrument reset is ignored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_r <= 8'h00;
            state_r <= SRSL_IDLE;
            irq_r <= '0;
        end else begin
            status_r <= status_nxt;
            state_r <= state_nxt;
            irq_r <= irq_nxt;
        end
    end

    // =====================================================
    // Outputs: both read paths share one register
    assign service_request_enable_mask = mask_r;
    assign status_summary_byte = status_r;
    assign serial_poll_byte = status_r;
    assign irq = irq_r;

    // =====================================================
    // Assertions
    property p_mask_write;
        @(posedge mclk) disable iff (sys_rst) mask_cmd.wr |=> service_request_enable_mask == $past(mask_cmd.data);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

    property p_summary_self;
        @(posedge mclk) disable iff (sys_rst) (status_raw & mask_r & 8'hbf) == 8'h00 |=> !status_summary_byte[6];
    endproperty
    a_summary_self: assert property (p_summary_self) else $error("summary set without cause");

    property p_summary_set;
        @(posedge mclk) disable iff (sys_rst) (status_raw & mask_r & 8'hbf) != 8'h00 |=> status_summary_byte[6];
    endproperty
    a_summary_set: assert property (p_summary_set) else $error("summary not set");

    property p_rise;
        @(posedge mclk) disable iff (sys_rst) irq.req_true |-> status_summary_byte[6] && !irq.req_false;
    endproperty
    a_rise: assert property (p_rise) else $error("request-true without summary");

    property p_fall;
        @(posedge mclk) disable iff (sys_rst) $fell(status_summary_byte[6]) |-> irq.req_false;
    endproperty
    a_fall: assert property (p_fall) else $error("request-false missing");

    property p_unused;
        @(posedge mclk) disable iff (sys_rst) (status_summary_byte & 8'h87) == 8'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bit set");

    property p_reply;
        @(posedge mclk) disable iff (sys_rst) reply_pending |=> status_summary_byte[4];
    endproperty
    a_reply: assert property (p_reply) else $error("reply flag missing");

    property p_event;
        @(posedge mclk) disable iff (sys_rst)
            |(standard_event_register & standard_event_enable_mask) |=> status_summary_byte[5];
    endproperty
    a_event: assert property (p_event) else $error("event flag missing");

    property p_ques;
        @(posedge mclk) disable iff (sys_rst) |(ques_cond & ques_enable) |=> status_summary_byte[3];
    endproperty
    a_ques: assert property (p_ques) else $error("questionable flag missing");

    property p_inst_rst;
        @(posedge mclk) disable iff (sys_rst) inst_rst && !mask_cmd.wr |=> $stable(service_request_enable_mask);
    endproperty
    a_inst_rst: assert property (p_inst_rst) else $error("mask changed by instrument reset");

    // =====================================================
    // Further checks on the read paths and the request pulses
    // Both read paths come from one register and must agree every cycle
    property p_serial_same;
        @(posedge mclk) disable iff (sys_rst) serial_poll_byte == status_summary_byte;
    endproperty
    a_serial_same: assert property (p_serial_same) else $error("serial poll byte differs from query byte");

    // A rise of the summary bit must carry a request-true pulse with it
    property p_rise_pulse;
        @(posedge mclk) disable iff (sys_rst) $rose(status_summary_byte[6]) |-> irq.req_true;
    endproperty
    a_rise_pulse: assert property (p_rise_pulse) else $error("request-true missing");

    // Request-true stands one cycle only
    property p_true_once;
        @(posedge mclk) disable iff (sys_rst) irq.req_true |=> !irq.req_true;
    endproperty
    a_true_once: assert property (p_true_once) else $error("request-true longer than one cycle");

    // Request-false only with the summary low and never with request-true
    property p_false_cause;
        @(posedge mclk) disable iff (sys_rst) irq.req_false |-> !status_summary_byte[6] && !irq.req_true;
    endproperty
    a_false_cause: assert property (p_false_cause) else $error("request-false without summary fall");

    // Request-false stands one cycle only
    property p_false_once;
        @(posedge mclk) disable iff (sys_rst) irq.req_false |=> !irq.req_false;
    endproperty
    a_false_once: assert property (p_false_once) else $error("request-false longer than one cycle");

    // No pulse while the summary bit stays put
    property p_quiet;
        @(posedge mclk) disable iff (sys_rst) $stable(status_summary_byte[6]) |-> !irq.req_true && !irq.req_false;
    endproperty
    a_quiet: assert property (p_quiet) else $error("request pulse without summary change");

    // Without a write the mask must hold its value
    property p_mask_hold;
        @(posedge mclk) disable iff (sys_rst) !mask_cmd.wr |=> $stable(service_request_enable_mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed without a write");

    // A mask holding only bit 6 can never raise the summary
    property p_bit6_only;
        @(posedge mclk) disable iff (sys_rst) service_request_enable_mask == 8'h40 |=> !status_summary_byte[6];
    endproperty
    a_bit6_only: assert property (p_bit6_only) else $error("summary enabled by mask bit 6");

    // Cleared conditions must clear their status bits a cycle later
    property p_ques_clear;
        @(posedge mclk) disable iff (sys_rst) (ques_cond & ques_enable) == 8'h00 |=> !status_summary_byte[3];
    endproperty
    a_ques_clear: assert property (p_ques_clear) else $error("questionable flag stuck");

    property p_reply_clear;
        @(posedge mclk) disable iff (sys_rst) !reply_pending |=> !status_summary_byte[4];
    endproperty
    a_reply_clear: assert property (p_reply_clear) else $error("reply flag stuck");

    property p_event_clear;
        @(posedge mclk) disable iff (sys_rst)
            (standard_event_register & standard_event_enable_mask) == 8'h00 |=> !status_summary_byte[5];
    endproperty
    a_event_clear: assert property (p_event_clear) else $error("event flag stuck");

    // Power-on reset clears the mask, the status byte and the pulses
    property p_mask_reset;
        @(posedge mclk) sys_rst |=> service_request_enable_mask == 8'h00 && status_summary_byte == 8'h00 && irq == '0;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("state not cleared by power-on reset");
endmodule

/* logic/srsl_defs.svh */
// Constants for the service request and status byte logic.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SRSL_DEFS_SVH
`define SRSL_DEFS_SVH
// =====================================================
// Status byte bit positions
`define SRSL_BIT_QUES 3
`define SRSL_BIT_REPLY 4
`define SRSL_BIT_EVENT 5
`define SRSL_BIT_SUMMARY 6
// Enable mask bits that take part in the summary (bit 6 excluded)
`define SRSL_SUMMARY_MASK 8'hbf
// Status byte bits that are never used and always read zero
`define SRSL_UNUSED_MASK 8'h87
// Reset value of the service request enable mask
`define SRSL_MASK_RST 8'h00
`endif

/* logic/srsl_pkg.sv */
// Types for the service request and status byte logic.
// Assumes the constants header is on the include path.
`include "srsl_defs.svh"
package srsl_pkg;
    // =====================================================
    // Interrupt pulses toward the bus controller
    typedef struct packed {
        logic req_true;  // Summary rose 0 to 1
        logic req_false; // Summary fell 1 to 0
    } srsl_irq_t;
    // Register write command from the command parser
    typedef struct packed {
        logic       wr;   // One-cycle write strobe
        logic [7:0] data; // Mask value 0 to 255
    } srsl_wr_t;
    // Summary state machine
    typedef enum logic [0:0] {SRSL_IDLE, SRSL_ACTIVE} srsl_state_t;
endpackage

/* test/srsl_commander.sv */
// Bus controller model that takes the request interrupts of the status logic.
// Assumes one-cycle pulses on mclk; it only counts them.
`timescale 1ns/1ps
module srsl_commander (
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Power-on reset, high
    input wire srsl_pkg::srsl_irq_t irq, // Request interrupt pulses
    output int n_true, // Request-true pulses seen
    output int n_false // Request-false pulses seen
);
    import srsl_pkg::*;
    // =====================================================
    // Counters: each high cycle is one interrupt, as the pulse stands one cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            n_true <= 0;
            n_false <= 0;
        end else begin
            n_true <= n_true + int'(irq.req_true);
            n_false <= n_false + int'(irq.req_false);
        end
    end
endmodule

/* test/testbench.sv */
// Self-checking bench for the status byte and request summary logic.
// Assumes inputs are synchronous to mclk; all are driven at the falling edge.
`timescale 1ns/1ps
module testbench;
    import srsl_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, inst_rst = 1'b0, reply_pending = 1'b0; // Clock, resets, reply flag
    srsl_wr_t mask_cmd = '0; // Mask write command
    logic [7:0] corner_masks [7] = '{8'h40, 8'hff, 8'h00, 8'h08, 8'h10, 8'h20, 8'hbf}; // Hand-picked masks
    logic [7:0] ques_cond = 8'h00, ques_enable = 8'h00, standard_event_register = 8'h00; // Condition inputs
    logic [7:0] standard_event_enable_mask = 8'h00, mask_exp = 8'h00, b_exp; // Event enable, expectations
    logic [7:0] service_request_enable_mask, status_summary_byte, serial_poll_byte; // Outputs
    logic prev = 1'b0; // Summary bit expected before the last step
    srsl_irq_t irq; // Request pulses
    int miscompares = 0, num_checks = 0, n_true, n_false, exp_true = 0, exp_false = 0; // Counters
    srsl_status i_srsl_status (.mclk(mclk), .sys_rst(sys_rst), .mask_cmd(mask_cmd), .inst_rst(inst_rst),
        .ques_cond(ques_cond), .ques_enable(ques_enable), .reply_pending(reply_pending),
        .standard_event_register(standard_event_register),
        .standard_event_enable_mask(standard_event_enable_mask),
        .service_request_enable_mask(service_request_enable_mask),
        .status_summary_byte(status_summary_byte), .serial_poll_byte(serial_poll_byte), .irq(irq));
    srsl_commander i_srsl_commander (.mclk(mclk), .sys_rst(sys_rst), .irq(irq), .n_true(n_true), .n_false(n_false));
    // =====================================================
    // Clock, 20 ns period
    initial begin
        forever #10 mclk = ~mclk;
    end
    // Expected status byte from the current inputs and the last mask written
    function automatic logic [7:0] exp_byte();
        logic [7:0] b;
        b = 8'h00; // Unused bits stay low
        b[3] = |(ques_cond & ques_enable);
        b[4] = reply_pending;
        b[5] = |(standard_event_register & standard_event_enable_mask);
        b[6] = |(b & mask_exp & 8'hbf); // Mask bit 6 left out
        return b;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Let the byte and summary settle, then compare everything visible
    task automatic settle();
        repeat (4) @(negedge mclk);
        b_exp = exp_byte();
        if (b_exp[6] && !prev) exp_true++;
        if (!b_exp[6] && prev) exp_false++;
        prev = b_exp[6];
        check(service_request_enable_mask, mask_exp, "mask readback");
        check(status_summary_byte, b_exp, "status byte");
        check(serial_poll_byte, b_exp, "serial poll byte");
        check(n_true, exp_true, "request-true count");
        check(n_false, exp_false, "request-false count");
    endtask
    task automatic set_mask(input logic [7:0] m);
        @(negedge mclk);
        mask_cmd = '{1'b1, m};
        mask_exp = m;
        @(negedge mclk);
        mask_cmd.wr = 1'b0;
        settle();
    endtask
    // Inputs change in a step of their own so the summary never sees a half-updated mask
    task automatic set_inputs(input logic [7:0] qc, qe, ser, see, input logic rp, ir);
        @(negedge mclk);
        {ques_cond, ques_enable, standard_event_register, standard_event_enable_mask} = {qc, qe, ser, see};
        reply_pending = rp;
        inst_rst = ir;
        @(negedge mclk);
        inst_rst = 1'b0;
        settle();
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =====================================================
    // Main sequence: reset, corner masks, random traffic, back-to-back writes
    initial begin
        void'($urandom(32'h92a24114));
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        check(service_request_enable_mask, 8'h00, "mask after reset");
        set_inputs(8'hff, 8'hff, 8'hff, 8'hff, 1'b1, 1'b0);
        foreach (corner_masks[i]) begin
            set_mask(corner_masks[i]);
        end
        for (int i = 0; i < 40; i++) begin
            set_mask(8'($urandom));
            set_inputs(8'($urandom & $urandom), 8'($urandom), 8'($urandom & $urandom), 8'($urandom),
                1'($urandom), 1'($urandom)); // Instrument reset must change nothing
        end
        set_inputs(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        @(negedge mclk);
        mask_cmd = '{1'b1, 8'h12};
        @(negedge mclk);
        mask_cmd.data = 8'h34;
        mask_exp = 8'h34;
        @(negedge mclk);
        mask_cmd.wr = 1'b0;
        settle(); // Last of two back-to-back writes wins
        complete_run();
    end
    // Watchdog well past the roughly 540 cycles the sequence needs
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule
